//--- design/tsa_consts.vh
// Constants for the temperature sensor alert and register access block.
`ifndef TSA_CONSTS_VH
`define TSA_CONSTS_VH

// Register select codes carried in pointer bits 2:0.
`define TSA_PTR_TEMP       3'h0
`define TSA_PTR_CFG        3'h1
`define TSA_PTR_HIGH       3'h2
`define TSA_PTR_LOW        3'h3
`define TSA_PTR_CTRL       3'h4
`define TSA_PTR_IDENT      3'h7

// Reset values, and the temperature read while a one-shot is pending.
`define TSA_RST_PTR        3'h0
`define TSA_RST_TEMP       16'h7ffc
`define TSA_ONESHOT_TEMP   16'h8000
`define TSA_RST_HIGH       11'h3ff
`define TSA_RST_LOW        11'h400
`define TSA_RST_RES        2'h0

// Configuration register field positions.
`define TSA_CFG_PD         7
`define TSA_CFG_RSV6       6
`define TSA_CFG_ALERT_DIS  5
`define TSA_CFG_ALERT_POL  4
`define TSA_CFG_ALERT_CLR  3
`define TSA_CFG_ONE_SHOT   2

// Control/status register field positions.
`define TSA_CS_TO_DIS      7
`define TSA_CS_RES_MSB     6
`define TSA_CS_RES_LSB     5
`define TSA_CS_ALERT_LVL   3
`define TSA_CS_ABOVE       2
`define TSA_CS_BELOW       1
`define TSA_CS_VALID       0

// Limit fields occupy bits 15:5 of the limit registers.
`define TSA_LIM_MSB        15
`define TSA_LIM_LSB        5

// SMBus alert response address.
`define TSA_ARA_ADDR       7'h0c

`endif

//--- design/tsa_sync.v
// Two-flop synchroniser for the bus pins.
`default_nettype none

module tsa_sync (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] din,
  output reg  [1:0] dout
);

  reg [1:0] meta_r;

  // Pins idle high, so both stages reset high.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 2'h3;
      dout   <= 2'h3;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- design/tsa_sensor_top.v
// Temperature sensor alert logic and two-wire register access.
//
// Overview of operation
// - After each conversion, drive alert active when reading exceeds high limit.
// - Alert level flag always equals the alert pin's logic level.
// - A reading below the low limit returns alert and flag inactive.
// - Writing one to alert clear bit deasserts alert and flag.
// - Completed alert response address read clears alert and flag.
// - After a clear, alert returns at next conversion if still above.
// - Each reading sets above-high and below-low flags from its comparisons.
// - Comparisons use only the 11-bit reading; low three bits ignored.
// - Pointer resets to 00h, selecting the temperature register.
// - Pointer keeps last valid value; pointerless reads use it.
// - Undefined pointer byte is not acknowledged and not stored.
// - Codes 0,1,2,3,4,7 select registers; 5 and 6 are invalid.
// - Read with preset pointer is address byte then data bytes.
// - Data shifts out MSB first; final ack or nack both accepted.
// - Conversion in progress finishes and updates result before shutdown.
// - Clearing shutdown bit resumes continuous conversion.
// - Temperature resets to 7FFCh; reads 8000h while one-shot pending.
// - Value in bits 15:2, bits 1:0 zero; valid once data flag set.
// - Resolution chosen by control/status bits 6 and 5.
// - Codes 00..11 give 11..14 bit left-justified words, low bits zero.
// - Polarity bit selects active level; disable bit turns alert off.
`include "tsa_consts.vh"
`default_nettype none

module tsa_sensor_top #(
  parameter [6:0]  SLAVE_ADDR = 7'h48,
  // Identification word; the value is arbitrary.
  parameter [15:0] IDENT_WORD = 16'h1234
) (
  input  wire        CORE_CLK,
  input  wire        RST_N,
  input  wire        SCL,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_N,
  output reg         ALERT_OUT,
  output reg         ALERT_OE_N,
  input  wire        CONV_DONE,
  input  wire [13:0] CONV_DATA,
  output reg         CONV_REQ
);

  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_ADDR   = 4'h1;
  localparam [3:0] ST_AACK   = 4'h2;
  localparam [3:0] ST_PTR    = 4'h3;
  localparam [3:0] ST_PACK   = 4'h4;
  localparam [3:0] ST_WDATA  = 4'h5;
  localparam [3:0] ST_WACK   = 4'h6;
  localparam [3:0] ST_RDATA  = 4'h7;
  localparam [3:0] ST_RACK   = 4'h8;

  wire [1:0] pins_s;
  reg        scl_d_r;
  reg        sda_d_r;

  tsa_sync u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .din   ({SCL, SDA_IN}),
    .dout  (pins_s)
  );

  wire scl_s    = pins_s[1];
  wire sda_s    = pins_s[0];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_strt = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Register state.
  reg [2:0]  ptr_r;
  reg [15:0] temp_r;
  reg [10:0] high_r;
  reg [10:0] low_r;
  reg        pd_r;
  reg        rsv6_r;
  reg        alert_dis_r;
  reg        alert_pol_r;
  reg        to_dis_r;
  reg [1:0]  res_r;
  reg        above_r;
  reg        below_r;
  reg        valid_r;
  reg        alert_act_r;
  reg        shut_r;
  reg        oneshot_r;

  // Link state.
  reg [3:0]  state_r;
  reg [2:0]  bit_cnt_r;
  reg [7:0]  rx_sh_r;
  reg [7:0]  tx_sh_r;
  reg        byte_idx_r;
  reg        rd_dir_r;
  reg        ara_r;
  reg        addr_ok_r;
  reg [7:0]  msb_hold_r;

  // Register write strobes and data, and the alert response done strobe, raised by the link.
  reg        wr_cfg_r;
  reg        wr_high_r;
  reg        wr_low_r;
  reg        wr_ctrl_r;
  reg [15:0] wr_data_r;
  reg        ara_done_r;

  // Incoming conversion, left-justified and cut to the chosen resolution.
  wire [15:0] conv_full = {CONV_DATA, 2'h0};
  reg  [15:0] conv_mask;

  always @* begin
    case (res_r)
      2'h0:    conv_mask = 16'hffe0;
      2'h1:    conv_mask = 16'hfff0;
      2'h2:    conv_mask = 16'hfff8;
      2'h3:    conv_mask = 16'hfffc;
      default: conv_mask = 16'hffe0;
    endcase
  end

  wire [15:0] conv_word = conv_full & conv_mask;
  wire signed [10:0] conv_11 = conv_word[15:5];
  wire signed [10:0] high_s  = high_r;
  wire signed [10:0] low_s   = low_r;
  wire conv_above = conv_11 > high_s;
  wire conv_below = conv_11 < low_s;

  wire alert_on   = alert_act_r & ~alert_dis_r;
  wire pin_level  = alert_pol_r ? alert_on : ~alert_on;

  wire ptr_valid  = (rx_sh_r[7:3] == 5'h00) &&
                    (rx_sh_r[2:0] != 3'h5) &&
                    (rx_sh_r[2:0] != 3'h6);

  // Register read word for the current pointer.
  wire [7:0] cfg_rd  = {pd_r, rsv6_r, alert_dis_r, alert_pol_r, 4'h0};
  wire [7:0] ctrl_rd = {to_dis_r, res_r, 1'b0, ALERT_OE_N,
                        above_r, below_r, valid_r};
  reg  [15:0] rd_word;
  reg         rd_wide;

  always @* begin
    rd_wide = 1'b1;
    case (ptr_r)
      `TSA_PTR_TEMP:
        rd_word = oneshot_r ? `TSA_ONESHOT_TEMP : temp_r;
      `TSA_PTR_CFG: begin
        rd_word = {cfg_rd, 8'h00};
        rd_wide = 1'b0;
      end
      `TSA_PTR_HIGH:  rd_word = {high_r, 5'h00};
      `TSA_PTR_LOW:   rd_word = {low_r, 5'h00};
      `TSA_PTR_CTRL: begin
        rd_word = {ctrl_rd, 8'h00};
        rd_wide = 1'b0;
      end
      `TSA_PTR_IDENT: rd_word = IDENT_WORD;
      default:        rd_word = 16'h0000;
    endcase
  end

  // High byte first, then low byte of two-byte registers.
  wire [7:0] tx_next = ara_r ? {SLAVE_ADDR, 1'b0} :
                       (rd_wide && byte_idx_r) ? rd_word[7:0] :
                       rd_word[15:8];

  // Two-wire slave.
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 3'h0;
      rx_sh_r    <= 8'h00;
      tx_sh_r    <= 8'h00;
      byte_idx_r <= 1'b0;
      rd_dir_r   <= 1'b0;
      ara_r      <= 1'b0;
      addr_ok_r  <= 1'b0;
      msb_hold_r <= 8'h00;
      ptr_r      <= `TSA_RST_PTR;
      SDA_OUT    <= 1'b0;
      SDA_OE_N   <= 1'b1;
      wr_cfg_r   <= 1'b0;
      wr_high_r  <= 1'b0;
      wr_low_r   <= 1'b0;
      wr_ctrl_r  <= 1'b0;
      wr_data_r  <= 16'h0000;
      ara_done_r <= 1'b0;
    end else begin
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
      wr_cfg_r   <= 1'b0;
      wr_high_r  <= 1'b0;
      wr_low_r   <= 1'b0;
      wr_ctrl_r  <= 1'b0;
      ara_done_r <= 1'b0;
      if (bus_strt) begin
        state_r    <= ST_ADDR;
        bit_cnt_r  <= 3'h0;
        byte_idx_r <= 1'b0;
        SDA_OE_N   <= 1'b1;
      end else if (bus_stop) begin
        state_r  <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else begin
        case (state_r)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              rx_sh_r   <= {rx_sh_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                if (state_r == ST_ADDR) begin
                  rd_dir_r  <= sda_s;
                  ara_r     <= (rx_sh_r[6:0] == `TSA_ARA_ADDR);
                  addr_ok_r <= (rx_sh_r[6:0] == SLAVE_ADDR) ||
                               ((rx_sh_r[6:0] == `TSA_ARA_ADDR) &&
                                sda_s && alert_act_r);
                  state_r   <= ST_AACK;
                end else if (state_r == ST_PTR) begin
                  state_r <= ST_PACK;
                end else begin
                  state_r <= ST_WACK;
                end
              end
            end
          end
          ST_AACK, ST_PACK, ST_WACK: begin
            if (scl_fall) begin
              if (SDA_OE_N) begin
                // First fall: acknowledge or walk away.
                if (state_r == ST_AACK && addr_ok_r) begin
                  SDA_OE_N <= 1'b0;
                end else if (state_r == ST_PACK && ptr_valid) begin
                  SDA_OE_N <= 1'b0;
                  ptr_r    <= rx_sh_r[2:0];
                end else if (state_r == ST_WACK) begin
                  SDA_OE_N <= 1'b0;
                  if (ptr_r == `TSA_PTR_CFG) begin
                    wr_cfg_r  <= 1'b1;
                    wr_data_r <= {rx_sh_r, 8'h00};
                  end else if (ptr_r == `TSA_PTR_CTRL) begin
                    wr_ctrl_r <= 1'b1;
                    wr_data_r <= {rx_sh_r, 8'h00};
                  end else if (!byte_idx_r) begin
                    msb_hold_r <= rx_sh_r;
                  end else begin
                    wr_high_r <= (ptr_r == `TSA_PTR_HIGH);
                    wr_low_r  <= (ptr_r == `TSA_PTR_LOW);
                    wr_data_r <= {msb_hold_r, rx_sh_r};
                  end
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                // Second fall: the acknowledge clock is over.
                bit_cnt_r <= 3'h0;
                if (state_r == ST_AACK && rd_dir_r) begin
                  tx_sh_r  <= {tx_next[6:0], 1'b0};
                  SDA_OE_N <= tx_next[7];
                  state_r  <= ST_RDATA;
                end else if (state_r == ST_AACK) begin
                  SDA_OE_N <= 1'b1;
                  state_r  <= ST_PTR;
                end else begin
                  SDA_OE_N   <= 1'b1;
                  state_r    <= ST_WDATA;
                  byte_idx_r <= (state_r == ST_WACK) ? ~byte_idx_r
                                                     : 1'b0;
                end
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise && ara_r && SDA_OE_N && !sda_s) begin
              // Lost alert response arbitration to a lower address.
              state_r <= ST_IDLE;
            end else if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                SDA_OE_N <= 1'b1;
                state_r  <= ST_RACK;
              end else begin
                SDA_OE_N <= tx_sh_r[7];
                tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ara_done_r <= ara_r;
              ara_r      <= 1'b0;
              byte_idx_r <= ~byte_idx_r;
              // Nack ends the read; ack asks for another byte.
              if (sda_s) begin
                state_r <= ST_IDLE;
              end
            end else if (scl_fall) begin
              bit_cnt_r <= 3'h0;
              tx_sh_r   <= {tx_next[6:0], 1'b0};
              SDA_OE_N  <= tx_next[7];
              state_r   <= ST_RDATA;
            end
          end
          ST_IDLE: begin
            SDA_OE_N <= 1'b1;
          end
          default: begin
            state_r  <= ST_IDLE;
            SDA_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end

  // Conversion, shutdown and alert logic.
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_r      <= `TSA_RST_TEMP;
      high_r      <= `TSA_RST_HIGH;
      low_r       <= `TSA_RST_LOW;
      pd_r        <= 1'b0;
      rsv6_r      <= 1'b1;
      alert_dis_r <= 1'b0;
      alert_pol_r <= 1'b0;
      to_dis_r    <= 1'b0;
      res_r       <= `TSA_RST_RES;
      above_r     <= 1'b0;
      below_r     <= 1'b0;
      valid_r     <= 1'b0;
      alert_act_r <= 1'b0;
      shut_r      <= 1'b0;
      oneshot_r   <= 1'b0;
      CONV_REQ    <= 1'b1;
      ALERT_OUT   <= 1'b0;
      ALERT_OE_N  <= 1'b1;
    end else begin
      if (wr_cfg_r) begin
        pd_r        <= wr_data_r[8 + `TSA_CFG_PD];
        rsv6_r      <= wr_data_r[8 + `TSA_CFG_RSV6];
        alert_dis_r <= wr_data_r[8 + `TSA_CFG_ALERT_DIS];
        alert_pol_r <= wr_data_r[8 + `TSA_CFG_ALERT_POL];
        if (!wr_data_r[8 + `TSA_CFG_PD]) begin
          shut_r <= 1'b0;
        end
        if (shut_r && wr_data_r[8 + `TSA_CFG_ONE_SHOT]) begin
          oneshot_r <= 1'b1;
          valid_r   <= 1'b0;
        end
      end
      if (wr_ctrl_r) begin
        to_dis_r <= wr_data_r[8 + `TSA_CS_TO_DIS];
        res_r    <= wr_data_r[8 + `TSA_CS_RES_LSB +: 2];
      end
      if (wr_high_r) begin
        high_r <= wr_data_r[`TSA_LIM_MSB:`TSA_LIM_LSB];
      end
      if (wr_low_r) begin
        low_r <= wr_data_r[`TSA_LIM_MSB:`TSA_LIM_LSB];
      end
      // Clears come first so that a same-cycle conversion still sets.
      if ((wr_cfg_r && wr_data_r[8 + `TSA_CFG_ALERT_CLR]) ||
          ara_done_r) begin
        alert_act_r <= 1'b0;
      end
      if (CONV_DONE && CONV_REQ) begin
        temp_r    <= conv_word;
        above_r   <= conv_above;
        below_r   <= conv_below;
        valid_r   <= 1'b1;
        oneshot_r <= 1'b0;
        if (conv_above) begin
          alert_act_r <= 1'b1;
        end else if (conv_below) begin
          alert_act_r <= 1'b0;
        end
        if (pd_r) begin
          shut_r <= 1'b1;
        end
      end
      // Shutdown waits for the running conversion to finish.
      CONV_REQ   <= ~shut_r | oneshot_r;
      ALERT_OUT  <= 1'b0;
      ALERT_OE_N <= pin_level;
    end
  end

endmodule

`default_nettype wire

//--- tb/tsa_host_model.sv
// Two-wire bus host model driving the clock and data lines.
`default_nettype none
module tsa_host_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input  wire logic clk,
  input  wire logic dev_oe_n,
  output var  logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low;
  // Pulled up: the wire is low while either party enables its driver.
  assign sda = !(host_low || !dev_oe_n);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  // A quarter bit; low and high phases last two quarters (800 ns) each.
  task automatic q();
    repeat (4) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    host_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start();
    host_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    host_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    host_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    host_low = 1'b0;
    q();
  endtask
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Every read ends with a not-acknowledge so the data line is free.
  task automatic get(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] p, input int n,
                    input logic [15:0] v, output logic pa);
    logic a;
    start();
    put({ADDR, 1'b0}, a);
    put(p, pa);
    if (n == 2)
      put(v[15:8], a);
    if (n > 0)
      put(v[7:0], a);
    stop();
  endtask
  task automatic rd(input logic [6:0] a7, input int n,
                    output logic [15:0] v, output logic aa);
    v = 16'h0000;
    start();
    put({a7, 1'b1}, aa);
    if (n == 2)
      get(1'b0, v[15:8]);
    get(1'b1, v[7:0]);
    stop();
  endtask
  task automatic rdp(input logic [7:0] p, input int n,
                     output logic [15:0] v);
    logic a;
    start();
    put({ADDR, 1'b0}, a);
    put(p, a);
    rd(ADDR, n, v, a);
  endtask
endmodule
`default_nettype wire

//--- tb/tsa_sensor_asserts.sv
// Port-level assertions for the sensor alert and register access block.
`default_nettype none
module tsa_sensor_asserts (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        SCL,
  input wire logic        SDA_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_N,
  input wire logic        ALERT_OUT,
  input wire logic        ALERT_OE_N,
  input wire logic        CONV_DONE,
  input wire logic [13:0] CONV_DATA,
  input wire logic        CONV_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_d_r;
  logic [5:0] quiet_r;
  logic [5:0] high_r;
  logic       busy;
  logic       conv_t;
  // Bus writes may move outputs for a while after any clock pin edge.
  assign busy   = quiet_r < 6'h14;
  assign conv_t = CONV_DONE && CONV_REQ;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d_r <= 1'b1;
      quiet_r <= 6'h3f;
      high_r  <= 6'h00;
    end else begin
      scl_d_r <= SCL;
      quiet_r <= (SCL != scl_d_r) ? 6'h00
                 : quiet_r + {5'h00, quiet_r != 6'h3f};
      high_r  <= !SCL ? 6'h00 : high_r + {5'h00, high_r != 6'h3f};
    end
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_conv;
    conv_t;
  endsequence
  a_reset_state: assert property (
    $rose(RST_N) |-> SDA_OE_N && ALERT_OE_N && CONV_REQ)
    else $error("outputs not idle after reset");
  a_sda_drain: assert property (SDA_OUT == 1'b0)
    else $error("data pin value not low");
  a_alert_drain: assert property (ALERT_OUT == 1'b0)
    else $error("alert pin value not low");
  a_sda_moves_low: assert property (
    $changed(SDA_OE_N) |-> !SCL && !$past(SCL))
    else $error("data line moved while clock high");
  a_alert_cause: assert property (
    $changed(ALERT_OE_N) |-> $past(conv_t, 2) || busy)
    else $error("alert moved without cause");
  a_alert_lag: assert property (
    s_conv ##1 !busy |-> $stable(ALERT_OE_N))
    else $error("alert moved one cycle after conversion");
  a_req_drop: assert property (
    $fell(CONV_REQ) |-> $past(conv_t) || $past(conv_t, 2))
    else $error("conversions stopped mid conversion");
  a_req_rise: assert property ($rose(CONV_REQ) |-> busy)
    else $error("conversions resumed without a write");
  a_idle_free: assert property (
    high_r > 6'h28 |-> SDA_OE_N)
    else $error("data line held on an idle bus");
  c_conv_alert: cover property (s_conv ##2 $changed(ALERT_OE_N));
endmodule
bind tsa_sensor_top tsa_sensor_asserts u_tsa_sensor_asserts (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ALERT_OUT(ALERT_OUT),
  .ALERT_OE_N(ALERT_OE_N), .CONV_DONE(CONV_DONE),
  .CONV_DATA(CONV_DATA), .CONV_REQ(CONV_REQ));
`default_nettype wire

//--- tb/tsa_sensor_top_bench.sv
// Self-checking bench for the sensor alert and register access block.
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tsa_sensor_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0]  DEV = 7'h48;
  // Identification word; the value is arbitrary.
  localparam logic [15:0] IDENT = 16'h1234;
  logic        core_clk;
  logic        rst_n;
  logic        conv_done;
  logic [13:0] conv_data;
  logic [15:0] d;
  logic        a;
  logic [7:0]  bad [3] = '{8'h05, 8'h06, 8'h0c};
  int          bad_count;
  int          tests_run;
  wire         scl;
  wire         sda;
  wire         sda_out;
  wire         sda_oe_n;
  wire         alert_out;
  wire         alert_oe_n;
  wire         conv_req;
  wire         alert_pin;
  // The alert line has a pull-up.
  assign alert_pin = alert_oe_n ? 1'b1 : alert_out;
  tsa_sensor_top #(.SLAVE_ADDR(DEV), .IDENT_WORD(IDENT)) u_tsa_sensor_top (
    .CORE_CLK  (core_clk),
    .RST_N     (rst_n),
    .SCL       (scl),
    .SDA_IN    (sda),
    .SDA_OUT   (sda_out),
    .SDA_OE_N  (sda_oe_n),
    .ALERT_OUT (alert_out),
    .ALERT_OE_N(alert_oe_n),
    .CONV_DONE (conv_done),
    .CONV_DATA (conv_data),
    .CONV_REQ  (conv_req)
  );
  tsa_host_model #(.ADDR(DEV)) host (
    .clk     (core_clk),
    .dev_oe_n(sda_oe_n),
    .scl     (scl),
    .sda     (sda)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic conv(input logic [13:0] v);
    @(negedge core_clk);
    conv_data = v;
    conv_done = conv_req;
    @(negedge core_clk);
    conv_done = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic fin(input string s);
    $display("test done: %s", s);
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_data = 14'h0000;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    host.rd(DEV, 2, d, a);
    `CHK(d, 16'h7ffc)
    host.wr(8'h00, 2, 16'h5555, a);
    host.rdp(8'h00, 2, d);
    `CHK(d, 16'h7ffc)
    host.rdp(8'h04, 1, d);
    `CHK(d, 16'h0008)
    // Nonzero upper pointer bits are sent here on purpose.
    foreach (bad[i]) begin
      host.wr(bad[i], 0, 16'h0000, a);
      `CHK(a, 1'b0)
      host.rd(DEV, 1, d, a);
      `CHK(d, 16'h0008)
    end
    fin("pointer");
    host.rdp(8'h01, 1, d);
    `CHK(d, 16'h0040)
    host.wr(8'h02, 2, 16'h0c80, a);
    host.wr(8'h03, 2, 16'h0080, a);
    host.rdp(8'h02, 2, d);
    `CHK(d, 16'h0c80)
    host.rdp(8'h03, 2, d);
    `CHK(d, 16'h0080)
    host.rdp(8'h07, 2, d);
    `CHK(d, IDENT)
    fin("registers");
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h04, 1, {9'h000, r[1:0], 5'h00}, a);
      conv(14'h0327);
      host.rdp(8'h00, 2, d);
      `CHK(d, 16'h0c9c & (16'hffff << (5 - r)))
      `CHK(alert_pin, 1'b1)
    end
    fin("resolution");
    conv(14'h0328);
    `CHK(alert_pin, 1'b0)
    host.rdp(8'h04, 1, d);
    `CHK(d, 16'h0065)
    host.wr(8'h01, 1, 16'h0048, a);
    `CHK(alert_pin, 1'b1)
    conv(14'h0328);
    `CHK(alert_pin, 1'b0)
    host.rd(7'h0c, 1, d, a);
    `CHK(a, 1'b1)
    `CHK(d, {8'h00, DEV, 1'b0})
    `CHK(alert_pin, 1'b1)
    conv(14'h0328);
    conv(14'h3fe0);
    `CHK(alert_pin, 1'b1)
    host.rdp(8'h04, 1, d);
    `CHK(d, 16'h006b)
    host.wr(8'h01, 1, 16'h0050, a);
    `CHK(alert_pin, 1'b0)
    // A reading above the limit while disabled leaves the pin inactive.
    host.wr(8'h01, 1, 16'h0060, a);
    conv(14'h0328);
    `CHK(alert_pin, 1'b1)
    host.rdp(8'h04, 1, d);
    `CHK(d, 16'h006d)
    host.wr(8'h01, 1, 16'h0040, a);
    `CHK(alert_pin, 1'b0)
    host.wr(8'h01, 1, 16'h0048, a);
    `CHK(alert_pin, 1'b1)
    fin("alert");
    // The shutdown bit stays set across the whole conversion.
    host.wr(8'h01, 1, 16'h00c0, a);
    `CHK(conv_req, 1'b1)
    conv(14'h0010);
    `CHK(conv_req, 1'b0)
    host.rdp(8'h00, 2, d);
    `CHK(d, 16'h0040)
    host.wr(8'h01, 1, 16'h00c4, a);
    host.rdp(8'h00, 2, d);
    `CHK(d, 16'h8000)
    `CHK(conv_req, 1'b1)
    conv(14'h0020);
    host.rdp(8'h00, 2, d);
    `CHK(d, 16'h0080)
    host.wr(8'h01, 1, 16'h0040, a);
    `CHK(conv_req, 1'b1)
    fin("shutdown");
    conclude();
  end
endmodule
`default_nettype wire
